// ---- rtl/edac_pkg.sv ----
// Package: register map, field layout and constants for the memory EDAC and scrub block
package edac_pkg;
  localparam int unsigned CODE_WORDS      = 32768;   // 128 KB of 32-bit words
  localparam int unsigned DATA_WORDS      = 8192;    // 32 KB of 32-bit words
  localparam int unsigned CODE_AW         = 15;
  localparam int unsigned DATA_AW         = 13;
  localparam int unsigned CHK_W           = 20;      // 5 check bits per byte
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned PER_W           = 24;

  localparam logic [11:0] OFF_CODE_PERIOD = 12'h000;
  localparam logic [11:0] OFF_DATA_PERIOD = 12'h004;
  localparam logic [11:0] OFF_CODE_TRAPA  = 12'h008;
  localparam logic [11:0] OFF_CODE_TRAPS  = 12'h00C;
  localparam logic [11:0] OFF_DATA_TRAPA  = 12'h010;
  localparam logic [11:0] OFF_DATA_TRAPS  = 12'h014;
  localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h018;
  localparam logic [11:0] OFF_FLAGS       = 12'h01C;
  localparam logic [11:0] OFF_FLAG_CLEAR  = 12'h020;
  localparam logic [11:0] OFF_DATA_SCNT   = 12'h024;
  localparam logic [11:0] OFF_DATA_MCNT   = 12'h028;
  localparam logic [11:0] OFF_CODE_SCNT   = 12'h02C;
  localparam logic [11:0] OFF_CODE_MCNT   = 12'h030;

  // Flag / enable bit positions
  localparam int unsigned BIT_DATA_SINGLE = 0;
  localparam int unsigned BIT_DATA_MULTI  = 1;
  localparam int unsigned BIT_CODE_SINGLE = 2;
  localparam int unsigned BIT_CODE_MULTI  = 3;
  localparam int unsigned TRAP_EN_BIT     = 31;

  localparam logic [PER_W-1:0] PERIOD_RESET = 24'h000000;
  localparam logic [3:0]       ENABLE_RESET = 4'h0;

  typedef enum logic [1:0] {
    MEM_IDLE  = 2'b00,
    MEM_CHECK = 2'b01,
    MEM_FIX   = 2'b10
  } mem_state_t;
endpackage

// ---- rtl/edac_mem_engine.sv ----
// One EDAC-protected memory with periodic scrub, trap injection and error pulses
`timescale 1ns/1ps
module edac_mem_engine #(
  parameter int unsigned AW    = 13,
  parameter int unsigned WORDS = 8192
) (
  input  wire logic                      pclk,        // CPU clock
  input  wire logic                      presetn,     // Async reset, active low
  input  wire logic [edac_pkg::PER_W-1:0] period,     // Scrub period, zero = off
  input  wire logic [31:0]               trap_addr,   // Bit 31 enable, low bits address
  input  wire logic [edac_pkg::CHK_W-1:0] trap_chk,   // Injected check bits
  input  wire logic                      cpu_req,     // CPU access strobe
  input  wire logic                      cpu_we,      // CPU write
  input  wire logic [AW-1:0]             cpu_addr,    // CPU word address
  input  wire logic [31:0]               cpu_wdata,   // CPU write data
  output logic      [31:0]               cpu_rdata,   // Corrected read data
  output logic                           cpu_rvalid,  // Read data valid
  output logic                           single_err,  // Correctable error pulse
  output logic                           multi_err,   // Uncorrectable error pulse
  output logic      [AW-1:0]             scrub_addr   // Scrub pointer
);
  import edac_pkg::*;

  logic [31:0]       mem_data [WORDS];
  logic [CHK_W-1:0]  mem_chk  [WORDS];
  logic [PER_W-1:0]  tick;
  logic              scrub_due;
  logic              rd_go;
  logic              rd_is_cpu;
  logic [AW-1:0]     rd_addr;
  logic [31:0]       rd_data;
  logic [CHK_W-1:0]  rd_chk;
  mem_state_t        state;
  logic [31:0]       fix_data;
  logic              any_multi;
  logic              any_single;
  logic              rd_is_cpu_q;

  // Check bits of one byte: four Hamming bits plus overall parity
  function automatic logic [4:0] byte_chk(input logic [7:0] d);
    logic [3:0] h;
    h[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    h[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    h[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
    h[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
    return {^{d, h}, h};
  endfunction

  function automatic logic [CHK_W-1:0] word_chk(input logic [31:0] d);
    return {byte_chk(d[31:24]), byte_chk(d[23:16]), byte_chk(d[15:8]), byte_chk(d[7:0])};
  endfunction

  // Scrub timer: one read every period cycles; keeps counting while CPU holds the array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick      <= PERIOD_RESET;
      scrub_due <= 1'b0;
    end else if (period == PERIOD_RESET) begin
      tick      <= PERIOD_RESET;
      scrub_due <= 1'b0;
    end else begin
      // Clear first so a new tick in the same cycle is never lost
      if (rd_go && !rd_is_cpu)
        scrub_due <= 1'b0;
      if (tick >= period - 1'b1) begin
        tick      <= PERIOD_RESET;
        scrub_due <= 1'b1;
      end else begin
        tick <= tick + 1'b1;
      end
    end
  end

  // CPU wins the port; scrub waits for a free cycle; reads pipeline so none is dropped
  always_comb begin
    rd_is_cpu = cpu_req && !cpu_we;
    rd_go     = rd_is_cpu || (scrub_due && !cpu_req);
  end

  // Whole array is swept in order, wrapping at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      scrub_addr <= '0;
    else if (rd_go && !rd_is_cpu)
      scrub_addr <= (scrub_addr == AW'(WORDS - 1)) ? '0 : scrub_addr + 1'b1;
  end

  // Decode: parity over the whole stored byte codeword odd is one bit, even with syndrome is many
  always_comb begin
    logic [4:0] s;
    logic [7:0] d;
    logic       par;
    s          = 5'h00;
    d          = 8'h00;
    par        = 1'b0;
    fix_data   = rd_data;
    any_multi  = 1'b0;
    any_single = 1'b0;
    for (int b = 0; b < 4; b++) begin
      d   = rd_data[8*b +: 8];
      s   = byte_chk(d) ^ rd_chk[5*b +: 5];
      par = ^{d, rd_chk[5*b +: 5]};
      if (par || s[3:0] != 4'h0) begin
        if (par) begin
          any_single = 1'b1;
          case (s[3:0])
            4'h3: fix_data[8*b+0] = ~d[0];
            4'h5: fix_data[8*b+1] = ~d[1];
            4'h6: fix_data[8*b+2] = ~d[2];
            4'h7: fix_data[8*b+3] = ~d[3];
            4'h9: fix_data[8*b+4] = ~d[4];
            4'hA: fix_data[8*b+5] = ~d[5];
            4'hB: fix_data[8*b+6] = ~d[6];
            4'hC: fix_data[8*b+7] = ~d[7];
            default: ;
          endcase
        end else begin
          any_multi = 1'b1;
        end
      end
    end
  end

  // Array port; CPU writes use trap check bits at the trap address
  always_ff @(posedge pclk) begin
    if (cpu_req && cpu_we) begin
      mem_data[cpu_addr] <= cpu_wdata;
      if (trap_addr[TRAP_EN_BIT] && trap_addr[AW-1:0] == cpu_addr)
        mem_chk[cpu_addr] <= trap_chk;
      else
        mem_chk[cpu_addr] <= word_chk(cpu_wdata);
    end else if (state == MEM_CHECK && any_single && !any_multi) begin
      mem_data[rd_addr] <= fix_data;
      mem_chk[rd_addr]  <= word_chk(fix_data);
    end
    if (rd_go) begin
      rd_data <= mem_data[rd_is_cpu ? cpu_addr : scrub_addr];
      rd_chk  <= mem_chk[rd_is_cpu ? cpu_addr : scrub_addr];
    end
  end

  // Read sequence and error pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= MEM_IDLE;
      rd_addr    <= '0;
      cpu_rdata  <= 32'h00000000;
      cpu_rvalid <= 1'b0;
      single_err <= 1'b0;
      multi_err  <= 1'b0;
    end else begin
      cpu_rvalid <= 1'b0;
      single_err <= 1'b0;
      multi_err  <= 1'b0;
      case (state)
        MEM_IDLE: begin
          if (rd_go) begin
            state   <= MEM_CHECK;
            rd_addr <= rd_is_cpu ? cpu_addr : scrub_addr;
          end
        end
        MEM_CHECK: begin
          state      <= rd_go ? MEM_CHECK : MEM_IDLE;
          if (rd_go)
            rd_addr <= rd_is_cpu ? cpu_addr : scrub_addr;
          cpu_rdata  <= fix_data;
          cpu_rvalid <= rd_is_cpu_q;
          single_err <= any_single && !any_multi;
          multi_err  <= any_multi;
        end
        default: state <= MEM_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rd_is_cpu_q <= 1'b0;
    else if (rd_go)
      rd_is_cpu_q <= rd_is_cpu;
  end

  AST_SCRUB_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (period == '0) |=> !scrub_due) else $error("scrub pending while disabled");
  AST_SINGLE_MULTI_EXCL: assert property (@(posedge pclk) disable iff (!presetn)
    !(single_err && multi_err)) else $error("single and multi error together");
  AST_CPU_NOT_STALLED: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_req && !cpu_we) |=> ##1 cpu_rvalid)
    else $error("cpu read stalled");
endmodule

// ---- rtl/memory_edac_scrub.sv ----
// Top: APB registers, code and data EDAC engines, error flags, counters and routing
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module memory_edac_scrub (
  input  wire logic                          pclk,               // CPU clock, 40 MHz
  input  wire logic                          presetn,            // Async reset, active low
  input  wire logic                          psel,               // APB select
  input  wire logic                          penable,            // APB enable
  input  wire logic                          pwrite,             // APB write
  input  wire logic [11:0]                   paddr,              // APB byte address
  input  wire logic [31:0]                   pwdata,             // APB write data
  output logic      [31:0]                   prdata,             // APB read data
  output logic                               pready,             // APB ready
  output logic                               pslverr,            // APB error
  input  wire logic                          code_req,           // Code memory access strobe
  input  wire logic                          code_we,            // Code write
  input  wire logic [edac_pkg::CODE_AW-1:0]  code_addr,          // Code word address
  input  wire logic [31:0]                   code_wdata,         // Code write data
  output logic      [31:0]                   code_rdata,         // Code read data
  output logic                               code_rvalid,        // Code read valid
  input  wire logic                          data_req,           // Data memory access strobe
  input  wire logic                          data_we,            // Data write
  input  wire logic [edac_pkg::DATA_AW-1:0]  data_addr,          // Data word address
  input  wire logic [31:0]                   data_wdata,         // Data write data
  output logic      [31:0]                   data_rdata,         // Data read data
  output logic                               data_rvalid,        // Data read valid
  output logic      [3:0]                    error_event,        // Per-source error pulses
  output logic                               error_interrupt_line, // Level interrupt
  output logic                               memory_error_reset_target, // Reset request pulse
  output logic                               code_reload_req     // Reload code memory from SPI
);
  import edac_pkg::*;

  logic [PER_W-1:0] code_period;
  logic [PER_W-1:0] data_period;
  logic [31:0]      code_trap_addr;
  logic [CHK_W-1:0] code_inject_checkbits;
  logic [31:0]      data_trap_addr;
  logic [CHK_W-1:0] data_inject_checkbits;
  logic [3:0]       irq_enable;
  logic [3:0]       err_flags;
  logic [3:0]       ev;
  logic [CNT_W-1:0] data_single_err_count;
  logic [CNT_W-1:0] data_multi_err_count;
  logic [CNT_W-1:0] code_single_err_count;
  logic [CNT_W-1:0] code_multi_err_count;
  logic [31:0]      code_rd;
  logic [31:0]      data_rd;
  logic             code_rv;
  logic             data_rv;
  logic             wr_en;
  logic             rd_en;
  logic [31:0]      next_prdata;
  logic             addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  edac_mem_engine #(.AW(CODE_AW), .WORDS(CODE_WORDS)) u_code (
    .pclk       (pclk),
    .presetn    (presetn),
    .period     (code_period),
    .trap_addr  (code_trap_addr),
    .trap_chk   (code_inject_checkbits),
    .cpu_req    (code_req),
    .cpu_we     (code_we),
    .cpu_addr   (code_addr),
    .cpu_wdata  (code_wdata),
    .cpu_rdata  (code_rd),
    .cpu_rvalid (code_rv),
    .single_err (ev[BIT_CODE_SINGLE]),
    .multi_err  (ev[BIT_CODE_MULTI]),
    .scrub_addr ()
  );

  edac_mem_engine #(.AW(DATA_AW), .WORDS(DATA_WORDS)) u_data (
    .pclk       (pclk),
    .presetn    (presetn),
    .period     (data_period),
    .trap_addr  (data_trap_addr),
    .trap_chk   (data_inject_checkbits),
    .cpu_req    (data_req),
    .cpu_we     (data_we),
    .cpu_addr   (data_addr),
    .cpu_wdata  (data_wdata),
    .cpu_rdata  (data_rd),
    .cpu_rvalid (data_rv),
    .single_err (ev[BIT_DATA_SINGLE]),
    .multi_err  (ev[BIT_DATA_MULTI]),
    .scrub_addr ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB: zero-wait, one access cycle
  always_comb begin
    wr_en = psel && penable && pwrite;
    rd_en = psel && !penable && !pwrite;
  end

  always_comb begin
    addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFF_CODE_MCNT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_period           <= PERIOD_RESET;
      data_period           <= PERIOD_RESET;
      code_trap_addr        <= 32'h00000000;
      code_inject_checkbits <= '0;
      data_trap_addr        <= 32'h00000000;
      data_inject_checkbits <= '0;
      irq_enable            <= ENABLE_RESET;
    end else if (wr_en) begin
      case (paddr)
        OFF_CODE_PERIOD: code_period <= pwdata[PER_W-1:0];
        OFF_DATA_PERIOD: data_period <= pwdata[PER_W-1:0];
        OFF_CODE_TRAPA:  code_trap_addr <= pwdata;
        OFF_CODE_TRAPS:  code_inject_checkbits <= pwdata[CHK_W-1:0];
        OFF_DATA_TRAPA:  data_trap_addr <= pwdata;
        OFF_DATA_TRAPS:  data_inject_checkbits <= pwdata[CHK_W-1:0];
        OFF_IRQ_ENABLE:  irq_enable <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    next_prdata = 32'h00000000;
    case (paddr)
      OFF_CODE_PERIOD: next_prdata = {8'h00, code_period};
      OFF_DATA_PERIOD: next_prdata = {8'h00, data_period};
      OFF_CODE_TRAPA:  next_prdata = code_trap_addr;
      OFF_CODE_TRAPS:  next_prdata = {12'h000, code_inject_checkbits};
      OFF_DATA_TRAPA:  next_prdata = data_trap_addr;
      OFF_DATA_TRAPS:  next_prdata = {12'h000, data_inject_checkbits};
      OFF_IRQ_ENABLE:  next_prdata = {28'h0000000, irq_enable};
      OFF_FLAGS:       next_prdata = {28'h0000000, err_flags};
      OFF_DATA_SCNT:   next_prdata = data_single_err_count;
      OFF_DATA_MCNT:   next_prdata = data_multi_err_count;
      OFF_CODE_SCNT:   next_prdata = code_single_err_count;
      OFF_CODE_MCNT:   next_prdata = code_multi_err_count;
      default:         next_prdata = 32'h00000000;
    endcase
  end

  // Read data latched in setup so prdata is a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en)
        prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags: an event in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      err_flags <= 4'h0;
    else if (wr_en && paddr == OFF_FLAG_CLEAR)
      err_flags <= (err_flags & ~pwdata[3:0]) | ev;
    else
      err_flags <= err_flags | ev;
  end

  // Counters saturate rather than wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_single_err_count <= '0;
      data_multi_err_count  <= '0;
      code_single_err_count <= '0;
      code_multi_err_count  <= '0;
    end else begin
      if (ev[BIT_DATA_SINGLE] && ~&data_single_err_count)
        data_single_err_count <= data_single_err_count + 1'b1;
      if (ev[BIT_DATA_MULTI] && ~&data_multi_err_count)
        data_multi_err_count <= data_multi_err_count + 1'b1;
      if (ev[BIT_CODE_SINGLE] && ~&code_single_err_count)
        code_single_err_count <= code_single_err_count + 1'b1;
      if (ev[BIT_CODE_MULTI] && ~&code_multi_err_count)
        code_multi_err_count <= code_multi_err_count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing: enabled single-bit sources interrupt, enabled multi-bit sources reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_event               <= 4'h0;
      error_interrupt_line      <= 1'b0;
      memory_error_reset_target <= 1'b0;
      code_reload_req           <= 1'b0;
      code_rdata                <= 32'h00000000;
      code_rvalid               <= 1'b0;
      data_rdata                <= 32'h00000000;
      data_rvalid               <= 1'b0;
    end else begin
      error_event               <= ev;
      error_interrupt_line      <= |(err_flags & irq_enable & 4'h5);
      memory_error_reset_target <= |(ev & irq_enable & 4'hA);
      code_reload_req           <= |(ev & irq_enable & 4'hA);
      code_rdata                <= code_rd;
      code_rvalid               <= code_rv;
      data_rdata                <= data_rd;
      data_rvalid               <= data_rv;
    end
  end

  AST_FLAG_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    ev[0] |=> err_flags[0]) else $error("event flag lost");
  AST_CLEAR_ALL: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFF_FLAG_CLEAR && pwdata[3:0] == 4'hF && ev == 4'h0) |=> err_flags == 4'h0)
    else $error("flags not cleared");
  AST_COUNT_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
    (ev[BIT_DATA_SINGLE] && ~&data_single_err_count) |=>
      data_single_err_count == $past(data_single_err_count) + 1'b1)
    else $error("single count not stepped");
  AST_COUNT_MULTI: assert property (@(posedge pclk) disable iff (!presetn)
    (!ev[BIT_CODE_MULTI]) |=> $stable(code_multi_err_count))
    else $error("multi count moved without event");
  AST_PERIOD_RESET: assert property (@(posedge pclk)
    $rose(presetn) |-> code_period == '0 && data_period == '0)
    else $error("period not zero after reset");
  AST_RESET_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
    (ev[BIT_CODE_MULTI] && irq_enable[BIT_CODE_MULTI]) |=> memory_error_reset_target && code_reload_req)
    else $error("multi error did not reset");
endmodule

// ---- verification/cpu_port.sv ----
// CPU-side requester model for one EDAC memory port
`timescale 1ns/1ps
module cpu_port #(
  parameter int unsigned AW = 13
) (
  input  wire logic          pclk,          // CPU clock
  output logic               req   = 1'b0,  // Access strobe
  output logic               we    = 1'b0,  // Write
  output logic [AW-1:0]      addr  = '0,    // Word address
  output logic [31:0]        wdata = '0     // Write data
);
  // One request, then a wait past the answer, so requests never crowd the engine
  task automatic access(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    @(posedge pclk);
    req <= 1'b0;
    wdata <= ~d;
    // Top-level valid and error pulses stand in the cycle after the second edge
    repeat (2) @(posedge pclk);
    #1;
  endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the memory EDAC and scrub block
`timescale 1ns/1ps
module tb;
  import edac_pkg::*;
  logic               pclk    = 1'b0;
  logic               presetn = 1'b0;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [11:0]        paddr   = 12'h000;
  logic [31:0]        pwdata  = 32'h00000000;
  logic [31:0]        prdata, code_rdata, data_rdata, rd, val;
  logic               pready, pslverr, code_rvalid, data_rvalid, irq, mreset, reload, err;
  logic               code_req, code_we, data_req, data_we;
  logic [CODE_AW-1:0] code_addr;
  logic [DATA_AW-1:0] data_addr;
  logic [31:0]        code_wdata, data_wdata;
  logic [3:0]         error_event;
  logic [31:0]        seed = 32'h783E1D6E;
  int                 n_mismatch = 0;
  int                 n_checks = 0;
  int                 n_sev = 0;
  int                 exp_ds = 0;

  memory_edac_scrub dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .code_req(code_req), .code_we(code_we), .code_addr(code_addr), .code_wdata(code_wdata),
    .code_rdata(code_rdata), .code_rvalid(code_rvalid), .data_req(data_req), .data_we(data_we),
    .data_addr(data_addr), .data_wdata(data_wdata), .data_rdata(data_rdata), .data_rvalid(data_rvalid),
    .error_event(error_event), .error_interrupt_line(irq), .memory_error_reset_target(mreset),
    .code_reload_req(reload));
  cpu_port #(.AW(CODE_AW)) cport (.pclk(pclk), .req(code_req), .we(code_we), .addr(code_addr),
    .wdata(code_wdata));
  cpu_port #(.AW(DATA_AW)) dport (.pclk(pclk), .req(data_req), .we(data_we), .addr(data_addr),
    .wdata(data_wdata));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (error_event[BIT_DATA_SINGLE] === 1'b1) n_sev++;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One full data sweep at period 2 dominates the run
  initial begin
    #(60000 * 25);
    n_mismatch++;
    finish_test();
  end

  initial begin
    int k;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_CODE_PERIOD, 0);
    chk(rd, 0);
    apb(0, OFF_DATA_PERIOD, 0);
    chk(rd, 0);
    for (k = 0; k < 4; k++) begin
      apb(0, OFF_DATA_SCNT + 12'(4 * k), 0);
      chk(rd, 0);
    end
    apb(0, 12'h040, 0);
    chk(err, 1);
    // Zero data word has zero check bits, so one flipped inner bit is a single error
    apb(1, OFF_DATA_TRAPA, 32'h80000000);
    apb(1, OFF_DATA_TRAPS, 32'h00000002);
    dport.access(1, 0, 0);
    for (k = 0; k < 2; k++) begin
      dport.access(0, 0, 0);
      chk({data_rvalid, data_rdata}, {1'b1, 32'h0});
      chk(error_event, (k == 0) ? 4'h1 : 4'h0);
      chk(irq, 0);
      if (k == 0) exp_ds++;
    end
    apb(0, OFF_DATA_SCNT, 0);
    chk(rd, exp_ds);
    apb(0, OFF_FLAGS, 0);
    chk(rd, 1 << BIT_DATA_SINGLE);
    apb(1, OFF_IRQ_ENABLE, 32'h0000000F);
    repeat (2) @(posedge pclk);
    #1;
    chk(irq, 1);
    apb(1, OFF_FLAG_CLEAR, 32'h0000000F);
    repeat (2) @(posedge pclk);
    #1;
    chk(irq, 0);
    apb(0, OFF_FLAGS, 0);
    chk(rd, 0);
    // Two flipped inner bits: uncorrectable, stays bad on every read
    apb(1, OFF_CODE_TRAPA, 32'h80000000);
    apb(1, OFF_CODE_TRAPS, 32'h00000006);
    cport.access(1, 0, 0);
    for (k = 0; k < 2; k++) begin
      cport.access(0, 0, 0);
      chk({error_event, mreset, reload}, {4'h8, 2'b11});
    end
    apb(0, OFF_CODE_MCNT, 0);
    chk(rd, 2);
    dport.access(1, 0, 0);
    repeat (200) @(posedge pclk);
    chk(n_sev, exp_ds);
    apb(1, OFF_DATA_PERIOD, 32'h00000002);
    for (k = 0; k < 2 * DATA_WORDS + 50 && n_sev <= exp_ds; k++) @(posedge pclk);
    exp_ds++;
    chk(n_sev, exp_ds);
    for (k = 0; k < 20; k++) begin
      val = xs();
      dport.access(1, 7, val);
      dport.access(0, 7, 0);
      chk({data_rvalid, data_rdata}, {1'b1, val});
    end
    repeat (2 * DATA_WORDS + 50) @(posedge pclk);
    chk(n_sev, exp_ds);
    apb(0, OFF_DATA_SCNT, 0);
    chk(rd, exp_ds);
    finish_test();
  end
endmodule
